// ===== sacc_consts.vh
// Constants for the converter clock and trigger control block
// Assumes inclusion by the design file and the test bench
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
// ==========================================
// Register byte offsets
`define SACC_OFF_SC1      8'h00
`define SACC_OFF_SC2      8'h04
`define SACC_OFF_RESH     8'h08
`define SACC_OFF_RESL     8'h0C
`define SACC_OFF_CMP      8'h10
`define SACC_OFF_CFG      8'h14
// ==========================================
// Field positions
`define SACC_SC1_DONE     7
`define SACC_SC1_IEN      6
`define SACC_SC1_CONT     5
`define SACC_SC2_ACT      7
`define SACC_SC2_HWT      6
`define SACC_SC2_CFE      5
`define SACC_SC2_CGT      4
`define SACC_CFG_LP       7
`define SACC_CFG_LSMP     4
`define SACC_CFG_MODE8    2
// ==========================================
// Reset values and codes
`define SACC_CH_OFF       5'h1F
`define SACC_SC1_RST      8'h1F
`define SACC_CLK_BUS      2'h0
`define SACC_CLK_BUS2     2'h1
`define SACC_CLK_ALT      2'h2
`define SACC_CLK_ASYNC    2'h3
// ==========================================
// Timing counts in conversion clock ticks, bit count and bus response codes
`define SACC_SAMPLE_SHORT 4'h3
`define SACC_SAMPLE_LONG  4'hF
`define SACC_BITS         10
`define SACC_RESP_OKAY    2'h0
`define SACC_RESP_SLVERR  2'h2
`endif

// ===== sacc_ctrl.v
// Converter clock selection, trigger and sequencing logic with AXI4-Lite registers
// Assumes all inputs except aclk-domain bus signals arrive asynchronously
//
// Contract
// RULE1: Four selectable conversion clock sources
// RULE2: Alternate clock comes from external reference
// RULE3: Software keeps divided clock in range
// RULE4: Alternate clock usable during wait mode
// RULE5: Alternate clock blocked in stop modes
// RULE6: Counter overflow starts conversion when enabled
// RULE7: Trigger ignores counter interrupt enable
// RULE8: Hardware trigger works run, wait, stop3
// RULE9: Ten-bit successive approximation search
// RULE10: Right-justified ten or eight bit result
// RULE11: Single or continuous; single returns idle
// RULE12: Completion flag with interrupt
// RULE13: Compare less-than or greater-equal with interrupt
// RULE14: Channel field selects among 28 inputs
// RULE15: Configurable sample time and power
// RULE16: Software converts bandgap then temperature
// RULE17: Control one write aborts and restarts
// RULE18: All-ones channel switches converter off
// RULE19: Done flag clears on write or low read
// RULE20: Overflow pulse synchronised before use
`timescale 1ns/1ps
`include "sacc_consts.vh"
module sacc_ctrl #(
   parameter SACC_W = 10
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address and data
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Clock sources and power modes
   input  wire        internal_async_conv_clock,
   input  wire        external_reference_clock,
   input  wire        wait_mode,
   input  wire        stop_mode,
   // Hardware trigger from real-time counter
   input  wire        hardware_trigger_input,
   // Analog front end
   input  wire        cmp_high,
   output reg  [4:0]  analog_channel,
   output reg  [SACC_W-1:0] dac_code,
   output reg         sample_hold,
   output reg         converter_on,
   output reg         low_power,
   // Interrupt and status
   output wire        irq
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SAMP = 2'h1;
   localparam ST_CONV = 2'h2;

   // ==========================================
   // Input synchronisers
   reg [1:0] alt_s_reg, async_s_reg, trig_s_reg, cmp_s_reg, stop_s_reg, wait_s_reg;
   reg       alt_d_reg, async_d_reg, trig_d_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         alt_s_reg   <= 2'h0;
         async_s_reg <= 2'h0;
         trig_s_reg  <= 2'h0;
         cmp_s_reg   <= 2'h0;
         stop_s_reg  <= 2'h0;
         wait_s_reg  <= 2'h0;
         alt_d_reg   <= 1'b0;
         async_d_reg <= 1'b0;
         trig_d_reg  <= 1'b0;
      end else begin
         alt_s_reg   <= {alt_s_reg[0], external_reference_clock};   // see RULE2
         async_s_reg <= {async_s_reg[0], internal_async_conv_clock};
         trig_s_reg  <= {trig_s_reg[0], hardware_trigger_input};   // see RULE20
         cmp_s_reg   <= {cmp_s_reg[0], cmp_high};
         stop_s_reg  <= {stop_s_reg[0], stop_mode};
         wait_s_reg  <= {wait_s_reg[0], wait_mode};
         alt_d_reg   <= alt_s_reg[1];
         async_d_reg <= async_s_reg[1];
         trig_d_reg  <= trig_s_reg[1];
      end
   end
   wire trig_pulse = trig_s_reg[1] & ~trig_d_reg;   // see RULE7

   // ==========================================
   // Registers
   reg [7:0]  sc1_reg;
   reg [7:0]  sc2_reg;
   reg [7:0]  cfg_reg;
   reg [9:0]  cmp_val_reg;
   reg [9:0]  result_reg;
   reg        done_reg;
   reg        act_reg;
   wire [4:0] chan = sc1_reg[4:0];
   wire       chan_off = (chan == `SACC_CH_OFF);   // see RULE18
   wire [1:0] clk_sel = cfg_reg[1:0];
   wire [1:0] clk_div = cfg_reg[6:5];

   // ==========================================
   // Conversion clock tick generation
   reg        bus_half_reg;
   reg [3:0]  div_cnt_reg;
   reg        src_tick;
   always @* begin
      case (clk_sel)   // see RULE1
         `SACC_CLK_BUS:  src_tick = 1'b1;
         `SACC_CLK_BUS2: src_tick = bus_half_reg;
         `SACC_CLK_ALT:  src_tick = alt_s_reg[1] & ~alt_d_reg & ~stop_s_reg[1];   // see RULE4 see RULE5
         default:        src_tick = async_s_reg[1] & ~async_d_reg;
      endcase
   end
   wire [3:0] div_top = (4'h1 << clk_div) - 4'h1;   // see RULE3
   wire       conv_tick = src_tick && (div_cnt_reg == div_top);
   always @(posedge aclk) begin
      if (!aresetn) begin
         bus_half_reg <= 1'b0;
         div_cnt_reg  <= 4'h0;
      end else begin
         bus_half_reg <= ~bus_half_reg;
         if (src_tick)
            div_cnt_reg <= (div_cnt_reg == div_top) ? 4'h0 : div_cnt_reg + 4'h1;
      end
   end

   // ==========================================
   // AXI4-Lite slave
   reg        aw_full_reg, w_full_reg;
   reg [7:0]  aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire       wr_go  = aw_full_reg & w_full_reg;
   wire       wr_lo  = wr_go & w_strb_reg[0];
   wire       rd_go  = s_axi_arvalid & s_axi_arready;
   wire       sc1_wr = wr_lo && (aw_addr_reg == `SACC_OFF_SC1);
   wire       resl_rd = rd_go && (s_axi_araddr == `SACC_OFF_RESL);
   wire       sw_start = sc1_wr && (w_data_reg[4:0] != `SACC_CH_OFF);   // see RULE17
   wire       hw_start = sc2_reg[`SACC_SC2_HWT] & trig_pulse & ~chan_off;   // see RULE6 see RULE8
   reg [9:0]  fmt_res;
   always @* begin
      if (cfg_reg[`SACC_CFG_MODE8])   // see RULE10
         fmt_res = {2'h0, result_reg[9:2]};
      else
         fmt_res = result_reg;
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SACC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `SACC_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
         sc1_reg      <= `SACC_SC1_RST;
         sc2_reg      <= 8'h00;
         cfg_reg      <= 8'h00;
         cmp_val_reg  <= 10'h000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `SACC_RESP_OKAY;
            if (aw_addr_reg == `SACC_OFF_SC1) begin
               if (w_strb_reg[0])
                  sc1_reg <= {1'b0, w_data_reg[6:0]};   // see RULE14
            end else if (aw_addr_reg == `SACC_OFF_SC2) begin
               if (w_strb_reg[0])
                  sc2_reg <= {1'b0, w_data_reg[6:4], 4'h0};   // see RULE13
            end else if (aw_addr_reg == `SACC_OFF_CMP) begin
               if (w_strb_reg[0])
                  cmp_val_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1])
                  cmp_val_reg[9:8] <= w_data_reg[9:8];
            end else if (aw_addr_reg == `SACC_OFF_CFG) begin
               if (w_strb_reg[0])
                  cfg_reg <= w_data_reg[7:0];   // see RULE15
            end else if (aw_addr_reg != `SACC_OFF_RESH && aw_addr_reg != `SACC_OFF_RESL) begin
               s_axi_bresp <= `SACC_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SACC_RESP_OKAY;
            if (s_axi_araddr == `SACC_OFF_SC1)
               s_axi_rdata <= {24'h000000, done_reg, sc1_reg[6:0]};
            else if (s_axi_araddr == `SACC_OFF_SC2)
               s_axi_rdata <= {24'h000000, act_reg, sc2_reg[6:0]};
            else if (s_axi_araddr == `SACC_OFF_RESH)
               s_axi_rdata <= {30'h0000000, fmt_res[9:8]};
            else if (s_axi_araddr == `SACC_OFF_RESL)
               s_axi_rdata <= {24'h000000, fmt_res[7:0]};
            else if (s_axi_araddr == `SACC_OFF_CMP)
               s_axi_rdata <= {22'h00000, cmp_val_reg};
            else if (s_axi_araddr == `SACC_OFF_CFG)
               s_axi_rdata <= {24'h000000, cfg_reg};
            else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `SACC_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // Conversion sequencer
   reg [1:0]  state_reg;
   reg [3:0]  samp_cnt_reg;
   reg [3:0]  bit_reg;
   wire [3:0] samp_len = cfg_reg[`SACC_CFG_LSMP] ? `SACC_SAMPLE_LONG : `SACC_SAMPLE_SHORT;
   wire [9:0] trial = dac_code;
   wire [9:0] final_code = cmp_s_reg[1] ? trial : (trial & ~(10'h001 << bit_reg));
   wire       cmp_true = sc2_reg[`SACC_SC2_CGT] ? (final_code >= cmp_val_reg) : (final_code < cmp_val_reg);
   // Comparator lags two edges behind each new trial code
   reg [1:0]  settle_reg;
   wire       step = conv_tick && (settle_reg == 2'h2);   // see RULE9
   wire       conv_end = (state_reg == ST_CONV) && step && (bit_reg == 4'h0);
   wire       set_done = conv_end && !sc1_wr && (!sc2_reg[`SACC_SC2_CFE] || cmp_true);   // see RULE13 see RULE17
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= ST_IDLE;
         samp_cnt_reg   <= 4'h0;
         bit_reg        <= 4'h0;
         settle_reg     <= 2'h0;
         dac_code       <= {SACC_W{1'b0}};
         result_reg     <= 10'h000;
         done_reg       <= 1'b0;
         act_reg        <= 1'b0;
         sample_hold    <= 1'b0;
         converter_on   <= 1'b0;
         low_power      <= 1'b0;
         analog_channel <= `SACC_CH_OFF;
      end else begin
         analog_channel <= chan;   // see RULE14
         settle_reg     <= (settle_reg == 2'h2) ? 2'h2 : settle_reg + 2'h1;
         low_power      <= cfg_reg[`SACC_CFG_LP];   // see RULE15
         if (set_done)
            done_reg <= 1'b1;   // see RULE12
         else if (sc1_wr || resl_rd)
            done_reg <= 1'b0;   // see RULE19
         if (sc1_wr && w_data_reg[4:0] == `SACC_CH_OFF) begin
            state_reg    <= ST_IDLE;   // see RULE18
            act_reg      <= 1'b0;
            sample_hold  <= 1'b0;
            converter_on <= 1'b0;
         end else if (sw_start || hw_start) begin
            state_reg    <= ST_SAMP;   // see RULE17
            samp_cnt_reg <= 4'h0;
            act_reg      <= 1'b1;
            sample_hold  <= 1'b1;
            converter_on <= 1'b1;
         end else begin
            case (state_reg)
               ST_SAMP: begin
                  if (conv_tick) begin
                     samp_cnt_reg <= samp_cnt_reg + 4'h1;
                     if (samp_cnt_reg == samp_len) begin
                        state_reg   <= ST_CONV;
                        sample_hold <= 1'b0;
                        bit_reg     <= 4'h9;
                        dac_code    <= 10'h200;
                        settle_reg  <= 2'h0;
                     end
                  end
               end
               ST_CONV: begin
                  if (step) begin   // see RULE9
                     if (bit_reg == 4'h0) begin
                        result_reg <= final_code;
                        dac_code   <= final_code;
                        if (sc1_reg[`SACC_SC1_CONT] && !chan_off) begin
                           state_reg    <= ST_SAMP;   // see RULE11
                           samp_cnt_reg <= 4'h0;
                           sample_hold  <= 1'b1;
                        end else begin
                           state_reg    <= ST_IDLE;
                           act_reg      <= 1'b0;
                           converter_on <= 1'b0;
                        end
                     end else begin
                        dac_code <= final_code | (10'h001 << (bit_reg - 4'h1));
                        bit_reg  <= bit_reg - 4'h1;
                        settle_reg <= 2'h0;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign irq = done_reg & sc1_reg[`SACC_SC1_IEN];   // see RULE12
endmodule // sacc_ctrl

// ===== sacc_ctrl_asserts.sv
// Concurrent checks on the converter control block's ports
// Assumes it is bound into every instance of the block
`timescale 1ns/1ps
module sacc_ctrl_asserts (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Bus handshakes
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Converter side
   input wire [4:0]  analog_channel,
   input wire        sample_hold,
   input wire        converter_on
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Conversion steps
   sequence s_start;
      $rose(converter_on);
   endsequence
   sequence s_sampling;
      ##[0:2] sample_hold;
   endsequence
   AST_START_SAMPLES: assert property (s_start |-> s_sampling)
      else $error("conversion began without sampling");
   AST_SAMPLE_ACTIVE: assert property (sample_hold |-> converter_on)
      else $error("sampling while idle");
   AST_RESET_OFF: assert property ($rose(aresetn) |-> analog_channel == 5'h1F && !converter_on)
      else $error("converter not off after reset");
   AST_OFF_IDLE: assert property (converter_on && analog_channel == 5'h1F |=> analog_channel != 5'h1F)
      else $error("converter running with channel off");
   // ==========================================
   // Register bus
   AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_AWBLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read response missing");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while held");
   AST_ARBLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17
      |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
      else $error("unmapped read not refused");
endmodule // sacc_ctrl_asserts
bind sacc_ctrl sacc_ctrl_asserts u_sacc_ctrl_asserts (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_channel(analog_channel),
   .sample_hold(sample_hold), .converter_on(converter_on));

// ===== sacc_front_model.sv
// Analog input and real-time counter model for the converter block
// Assumes the bench clock and the block's trial code
`timescale 1ns/1ps
module sacc_front_model #(
   parameter RTC_MOD = 200
) (
   // Clock and control
   input  wire       aclk,
   input  wire       rtc_run,
   // Converter side
   input  wire [4:0] analog_channel,
   input  wire [9:0] dac_code,
   output wire       cmp_high,
   output wire       hardware_trigger_input
);
   reg [7:0] cnt_reg = 8'h00;
   // Level per channel; comparator high while the trial code is at or below it
   assign cmp_high = (dac_code <= {analog_channel, 5'h15});
   // Overflow pulse, no interrupt enable involved
   assign hardware_trigger_input = rtc_run && (cnt_reg < 8'h04);
   always @(posedge aclk) begin
      cnt_reg <= (!rtc_run || cnt_reg == RTC_MOD) ? 8'h00 : cnt_reg + 8'h01;
   end
endmodule // sacc_front_model

// ===== sacc_ctrl_test.sv
// Self-checking bench for the converter control block
// Assumes the front model stands on the analog and trigger side
`timescale 1ns/1ps
`include "sacc_consts.vh"
module sacc_ctrl_test;
   reg          aclk = 1'b0, aresetn = 1'b0, async_clk = 1'b0, ref_clk = 1'b0;
   reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg          wait_mode = 1'b0, stop_mode = 1'b0, rtc_run = 1'b0;
   reg  [7:0]   awaddr = 8'h00, araddr = 8'h00;
   reg  [31:0]  wdata = 32'h0;
   wire         awready, wready, bvalid, arready, rvalid, cmp_high, hw_trig;
   wire         sample_hold, converter_on, low_power, irq;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [4:0]   chan;
   wire [9:0]   dac;
   logic [31:0] rd;
   logic [1:0]  rs;
   integer      err_total = 0, comparisons = 0, cyc = 0, i, n;
   // ==========================================
   // Clocks and design
   initial forever #50 aclk = ~aclk;
   initial forever #187.3 async_clk = ~async_clk;
   initial forever #263.7 ref_clk = ~ref_clk;
   sacc_ctrl #(.SACC_W(10)) u_sacc_ctrl (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .internal_async_conv_clock(async_clk), .external_reference_clock(ref_clk), .wait_mode(wait_mode),
      .stop_mode(stop_mode), .hardware_trigger_input(hw_trig), .cmp_high(cmp_high),
      .analog_channel(chan), .dac_code(dac), .sample_hold(sample_hold), .converter_on(converter_on),
      .low_power(low_power), .irq(irq));
   sacc_front_model u_sacc_front_model (.aclk(aclk), .rtc_run(rtc_run), .analog_channel(chan),
      .dac_code(dac), .cmp_high(cmp_high), .hardware_trigger_input(hw_trig));
   // ==========================================
   // Bus tasks and checks
   task close_out;
      begin
         $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while ((awvalid && !awready) || (wvalid && !wready));
         do @(posedge aclk); while (bvalid !== 1'b1);
         rs = bresp;
         bready <= 1'b0;
      end
   endtask
   task rd_reg(input logic [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge aclk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         do @(posedge aclk); while (rvalid !== 1'b1);
         rd = rdata;
         rs = rresp;
         rready <= 1'b0;
      end
   endtask
   task wait_done;
      begin
         n = 0;
         do begin
            rd_reg(`SACC_OFF_SC1);
            n = n + 1;
         end while (rd[7] !== 1'b1 && n < 500);
      end
   endtask
   task run(input logic [31:0] c, input logic [31:0] s);
      begin
         wr(`SACC_OFF_CFG, c);
         wr(`SACC_OFF_SC1, s);
         wait_done;
      end
   endtask
   task check_res(input logic [9:0] v);
      begin
         rd_reg(`SACC_OFF_RESH);
         check(rd, {30'h0, v[9:8]});
         rd_reg(`SACC_OFF_RESL);
         check(rd, {24'h0, v[7:0]});
      end
   endtask
   function [9:0] lvl(input [4:0] c);
      lvl = {c, 5'h15};
   endfunction
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         err_total = err_total + 1;
         close_out;
      end
   end
   // ==========================================
   // Scenarios
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(`SACC_OFF_SC1);
      check(rd, 32'h1F);
      rd_reg(8'h40);
      check(rd, 32'h0);
      check(rs, `SACC_RESP_SLVERR);
      wr(8'h40, 32'h0);
      check(rs, `SACC_RESP_SLVERR);
      for (i = 0; i < 4; i = i + 1) begin
         run({24'h0, (i == 3) ? 8'h93 : {6'h0, i[1:0]}}, 32'h1B);
         check(rd[7], 1'b1);
         check(chan, 5'h1B);
         check(low_power, i == 3);
         check(converter_on, 1'b0);
         check_res(lvl(5'h1B));
      end
      run(32'hF3, 32'h1B);
      check_res(lvl(5'h1B));
      run(32'hF3, 32'h1A);
      check_res(lvl(5'h1A));
      run(32'h04, 32'h1B);
      check_res(lvl(5'h1B) >> 2);
      wr(`SACC_OFF_CMP, 32'h100);
      check(rs, `SACC_RESP_OKAY);
      wr(`SACC_OFF_SC2, 32'h30);
      run(32'h0, 32'h05);
      check(rd[7], 1'b0);
      run(32'h0, 32'h1B);
      check(rd[7], 1'b1);
      wr(`SACC_OFF_SC2, 32'h20);
      run(32'h0, 32'h05);
      check(rd[7], 1'b1);
      wr(`SACC_OFF_SC2, 32'h0);
      stop_mode <= 1'b1;
      run(32'h02, 32'h05);
      check(rd[7], 1'b0);
      stop_mode <= 1'b0;
      wait_mode <= 1'b1;
      wait_done;
      check(rd[7], 1'b1);
      check_res(lvl(5'h05));
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      wr(`SACC_OFF_SC2, 32'h40);
      run(32'h03, 32'h03);
      check_res(lvl(5'h03));
      rd_reg(`SACC_OFF_SC1);
      check(rd[7], 1'b0);
      rtc_run <= 1'b1;
      wait_done;
      check(rd[7], 1'b1);
      rtc_run <= 1'b0;
      stop_mode <= 1'b0;
      wr(`SACC_OFF_SC2, 32'h0);
      wr(`SACC_OFF_SC1, 32'h05);
      repeat (20) @(posedge aclk);
      wr(`SACC_OFF_SC1, 32'h1B);
      wait_done;
      check_res(lvl(5'h1B));
      run(32'h0, 32'h25);
      rd_reg(`SACC_OFF_RESL);
      wait_done;
      check(rd[7], 1'b1);
      wr(`SACC_OFF_SC1, 32'h1F);
      repeat (4) @(posedge aclk);
      check(converter_on, 1'b0);
      repeat (60) @(posedge aclk);
      rd_reg(`SACC_OFF_SC1);
      check(rd, 32'h1F);
      run(32'h0, 32'h45);
      check(irq, 1'b1);
      rd_reg(`SACC_OFF_RESL);
      repeat (2) @(posedge aclk);
      check(irq, 1'b0);
      close_out;
   end
endmodule // sacc_ctrl_test
